/* File: hdl/pp_pkg.sv */
package pp_pkg;
    // register offsets from the port base
    localparam logic [2:0] PP_OFS_DATA = 3'h0;
    localparam logic [2:0] PP_OFS_STATUS = 3'h1;
    localparam logic [2:0] PP_OFS_CTRL = 3'h2;
    localparam logic [2:0] PP_OFS_EPP_DATA = 3'h4;
    // peripheral_status fields
    localparam int PP_ST_BUSY = 7;
    localparam int PP_ST_ACCEPT = 6;
    localparam int PP_ST_PAPER = 5;
    localparam int PP_ST_ONLINE = 4;
    localparam int PP_ST_FAULT = 3;
    localparam int PP_ST_TMO = 0;
    // control fields
    localparam int PP_CT_STROBE = 0;
    localparam int PP_CT_AFD = 1;
    localparam int PP_CT_INIT = 2;
    localparam int PP_CT_SELIN = 3;
    localparam int PP_CT_IRQEN = 4;
    localparam int PP_CT_DIR = 5;
    localparam int PP_CTRL_W = 6;
    localparam logic [5:0] PP_CTRL_RESET = 6'h04;
    localparam logic [1:0] PP_CTRL_RD_PAD = 2'h3;
    localparam logic [7:0] PP_EPP_TMO_DATA = 8'hff;
    // timing
    localparam int PP_CLK_PERIOD_NS = 100;
    localparam int PP_EPP_TMO_NS = 10000;
    localparam int PP_EPP_TMO_CYC = PP_EPP_TMO_NS / PP_CLK_PERIOD_NS;
    localparam int PP_IRQ_PULSE_NS = 500;
    localparam int PP_IRQ_PULSE_CYC =
        (PP_IRQ_PULSE_NS + PP_CLK_PERIOD_NS - 1) / PP_CLK_PERIOD_NS;
    localparam int PP_FIFO_DEPTH = 16;
    localparam int PP_SYNC_W = 16;

    typedef enum logic [1:0] {
        PP_MODE_SPP,
        PP_MODE_PS2,
        PP_MODE_EPP,
        PP_MODE_ECP
    } pp_mode_t;

    typedef enum logic [1:0] {
        PP_ENG_IDLE,
        PP_ENG_WR,
        PP_ENG_RD,
        PP_ENG_END
    } pp_eng_t;
endpackage

/* File: hdl/pp_port.sv */
`timescale 1ns/100ps
`default_nettype none

module pp_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("pp_fifo: DEPTH must be a power of two >= 2");
    end

    wire full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire empty_w = (wr_ptr_r == rd_ptr_r);
    wire push_w = in_valid && !full_w;
    wire pop_w = out_ready && !empty_w;

    assign in_ready = !full_w;
    assign out_valid = !empty_w;
    assign out_data = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge mclk)
    begin
        if (push_w)
            mem[wr_ptr_r[AW-1:0]] <= in_data;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push_w)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop_w)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule // pp_fifo

// Operation
// [R1] strobe output is the inverse of control bit 0
// [R2] status bit 7 reads the inverted busy input
// [R3] status bit 6 reads the acknowledge input as is
// [R4] status bit 5 reads the paper-out input
// [R5] status bit 4 reads the online input
// [R6] status bit 3 reads the fault input as is
// [R7] peripheral holds busy high while it cannot take data
// [R8] peripheral pulls acknowledge low once the byte is taken
// [R9] eight data lines carry bytes in either direction
// [R10] in EPP mode hold IOCHRDY low until peripheral transfer completes; on a write the code holds it only until the byte enters the fifo
// [R11] in EPP or ECP mode interrupt is a low pulse then release
// [R12] select-in output is the inverse of control bit 3
// [R13] init output follows control bit 2 directly
// [R14] auto line feed output is the inverse of control bit 1
module pp_port
    import pp_pkg::*;
#(
    parameter int TMO_CYC = PP_EPP_TMO_CYC,
    parameter int IRQ_CYC = PP_IRQ_PULSE_CYC,
    parameter int FIFO_DEPTH = PP_FIFO_DEPTH
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] port_mode,
    input wire logic [2:0] host_addr,
    input wire logic host_cs_n,
    input wire logic host_ior_n,
    input wire logic host_iow_n,
    input wire logic [7:0] host_d_in,
    output logic [7:0] host_d_out,
    output logic host_d_oe,
    output logic iochrdy_o,
    output logic iochrdy_oe,
    output logic irq_o,
    output logic irq_oe,
    output logic data_latch_pulse_n,
    output logic auto_line_feed_n,
    output logic peripheral_init_n,
    output logic select_peripheral_n,
    input wire logic busy,
    input wire logic peripheral_accept_n,
    input wire logic paper_out,
    input wire logic peripheral_online,
    input wire logic peripheral_fault_n,
    input wire logic [7:0] port_data_lines_in,
    output logic [7:0] port_data_lines_out,
    output logic port_data_lines_oe
);
    initial
    begin
        if (TMO_CYC < 1 || TMO_CYC > 255 || IRQ_CYC < 1 || IRQ_CYC > 255)
            $error("pp_port: counts must lie in 1..255");
    end

    // every peripheral pin and host strobe passes two flops before use
    logic [PP_SYNC_W-1:0] s1_r;
    logic [PP_SYNC_W-1:0] s2_r;
    wire [PP_SYNC_W-1:0] raw_w = {host_cs_n, host_ior_n, host_iow_n,
                                  busy, peripheral_accept_n, paper_out,
                                  peripheral_online, peripheral_fault_n,
                                  port_data_lines_in};

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s1_r <= '1;
            s2_r <= '1;
        end
        else
        begin
            s1_r <= raw_w;
            s2_r <= s1_r;
        end
    end

    wire cs_s = !s2_r[15];
    wire ior_s = !s2_r[14];
    wire iow_s = !s2_r[13];
    wire busy_s = s2_r[12];
    wire accept_n_s = s2_r[11];
    wire paper_s = s2_r[10];
    wire online_s = s2_r[9];
    wire fault_n_s = s2_r[8];
    wire [7:0] pd_s = s2_r[7:0];

    logic ior_d_r;
    logic iow_d_r;
    logic accept_n_d_r;
    wire rd_go_w = ior_s && !ior_d_r && cs_s;
    wire wr_go_w = iow_s && !iow_d_r && cs_s;
    wire accept_fall_w = accept_n_d_r && !accept_n_s;

    wire pp_mode_t mode_w = pp_mode_t'(port_mode);
    wire epp_w = (mode_w == PP_MODE_EPP);
    wire shared_irq_w = epp_w || (mode_w == PP_MODE_ECP);

    logic [PP_CTRL_W-1:0] ctrl_r;
    logic [7:0] pd_out_r;
    logic [7:0] rd_data_r;
    logic wr_pend_r;
    logic [7:0] wr_data_r;
    logic rd_pend_r;
    logic tmo_flag_r;
    logic irq_lvl_r;
    logic [7:0] irq_cnt_r;
    logic [7:0] tmo_cnt_r;
    logic eng_write_r;
    pp_eng_t state_r;
    pp_eng_t state_nxt;

    // address decode
    wire sel_data_w = (host_addr == PP_OFS_DATA);
    wire sel_status_w = (host_addr == PP_OFS_STATUS);
    wire sel_ctrl_w = (host_addr == PP_OFS_CTRL);
    wire sel_epp_w = (host_addr == PP_OFS_EPP_DATA) && epp_w;
    wire push_req_w = wr_go_w && (sel_data_w || sel_epp_w);

    wire [7:0] status_w = {!busy_s, accept_n_s, paper_s, online_s,
                           fault_n_s, 2'b00, tmo_flag_r}; // see [R2] [R3] [R4] [R5] [R6]
    wire dir_in_w = ctrl_r[PP_CT_DIR] && (mode_w != PP_MODE_SPP);
    wire [7:0] rd_mux_w =
        sel_status_w ? status_w :
        sel_ctrl_w ? {PP_CTRL_RD_PAD, ctrl_r} :
        sel_data_w ? (dir_in_w ? pd_s : pd_out_r) : 8'h00;

    // host data writes wait in a holding register until the fifo has room
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire fifo_pop_w = (state_r == PP_ENG_IDLE) && fifo_out_valid;

    pp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(wr_pend_r),
        .in_ready(fifo_in_ready),
        .in_data(wr_data_r),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop_w),
        .out_data(fifo_out_data)
    );

    // epp handshake engine; in other modes it only drains the fifo
    wire tmo_w = (tmo_cnt_r == 8'(TMO_CYC - 1));
    wire rd_start_w = (state_r == PP_ENG_IDLE) && !fifo_out_valid &&
                      rd_pend_r && epp_w;
    wire rd_done_w = (state_r == PP_ENG_RD) && (busy_s || tmo_w);
    wire tmo_evt_w = ((state_r == PP_ENG_WR) || (state_r == PP_ENG_RD) ||
                      (state_r == PP_ENG_END)) && tmo_w &&
                     !((state_r == PP_ENG_END) ? !busy_s : busy_s);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            PP_ENG_IDLE:
            begin
                if (fifo_pop_w && epp_w)
                    state_nxt = PP_ENG_WR;
                else if (rd_start_w)
                    state_nxt = PP_ENG_RD;
            end
            PP_ENG_WR:
            begin
                if (busy_s || tmo_w)
                    state_nxt = PP_ENG_END;
            end
            PP_ENG_RD:
            begin
                if (busy_s || tmo_w)
                    state_nxt = PP_ENG_END;
            end
            PP_ENG_END:
            begin
                if (!busy_s || tmo_w)
                    state_nxt = PP_ENG_IDLE;
            end
            default:
                state_nxt = PP_ENG_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_r <= PP_ENG_IDLE;
            tmo_cnt_r <= 8'h00;
            eng_write_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            tmo_cnt_r <= (state_nxt != state_r) ? 8'h00 : tmo_cnt_r + 8'h01;
            if (state_r == PP_ENG_IDLE)
                eng_write_r <= fifo_pop_w;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ior_d_r <= 1'b0;
            iow_d_r <= 1'b0;
            accept_n_d_r <= 1'b1;
            ctrl_r <= PP_CTRL_RESET;
            pd_out_r <= 8'h00;
            wr_pend_r <= 1'b0;
            wr_data_r <= 8'h00;
        end
        else
        begin
            ior_d_r <= ior_s;
            iow_d_r <= iow_s;
            accept_n_d_r <= accept_n_s;
            if (wr_go_w && sel_ctrl_w)
                ctrl_r <= host_d_in[PP_CTRL_W-1:0];
            if (push_req_w)
            begin
                wr_pend_r <= 1'b1;
                wr_data_r <= host_d_in;
            end
            else if (fifo_in_ready)
                wr_pend_r <= 1'b0;
            if (fifo_pop_w)
                pd_out_r <= fifo_out_data;
        end
    end

    // read data and flags; a setting event wins over a read that clears
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rd_data_r <= 8'h00;
            rd_pend_r <= 1'b0;
            tmo_flag_r <= 1'b0;
            irq_lvl_r <= 1'b0;
            irq_cnt_r <= 8'h00;
        end
        else
        begin
            if (rd_go_w && sel_epp_w)
                rd_pend_r <= 1'b1;
            else if (rd_done_w)
                rd_pend_r <= 1'b0;
            if (rd_go_w && !sel_epp_w)
                rd_data_r <= rd_mux_w;
            else if (rd_done_w)
                rd_data_r <= busy_s ? pd_s : PP_EPP_TMO_DATA;
            if (tmo_evt_w)
                tmo_flag_r <= 1'b1;
            else if (rd_go_w && sel_status_w)
                tmo_flag_r <= 1'b0;
            if (accept_fall_w && ctrl_r[PP_CT_IRQEN])
                irq_lvl_r <= 1'b1;
            else if (rd_go_w && sel_status_w)
                irq_lvl_r <= 1'b0;
            if (accept_fall_w && ctrl_r[PP_CT_IRQEN] && shared_irq_w)
                irq_cnt_r <= 8'(IRQ_CYC); // see [R11]
            else if (irq_cnt_r != 8'h00)
                irq_cnt_r <= irq_cnt_r - 8'h01;
        end
    end

    wire eng_busy_w = (state_r == PP_ENG_WR) || (state_r == PP_ENG_RD);
    wire eng_read_w = (state_r == PP_ENG_RD) ||
                      ((state_r == PP_ENG_END) && !eng_write_r);
    wire eng_wr_cyc_w = (state_r == PP_ENG_WR) ||
                        ((state_r == PP_ENG_END) && eng_write_r);

    assign host_d_out = rd_data_r;
    assign host_d_oe = ior_s && cs_s && !rd_pend_r;
    // stall the host while its epp byte cannot enter the fifo or a read runs
    assign iochrdy_o = 1'b0;
    assign iochrdy_oe = epp_w && (wr_pend_r || rd_pend_r); // see [R10]
    // shared line: drive low only for the pulse, then let it float
    assign irq_o = shared_irq_w ? 1'b0 : irq_lvl_r;
    assign irq_oe = shared_irq_w ? (irq_cnt_r != 8'h00) :
                    ctrl_r[PP_CT_IRQEN]; // see [R11]
    // epp reuses strobe as write, autofeed as data strobe
    assign data_latch_pulse_n = epp_w ? !eng_wr_cyc_w :
                                !ctrl_r[PP_CT_STROBE]; // see [R1]
    assign auto_line_feed_n = epp_w ? !eng_busy_w :
                              !ctrl_r[PP_CT_AFD]; // see [R14]
    assign peripheral_init_n = ctrl_r[PP_CT_INIT]; // see [R13]
    assign select_peripheral_n = !ctrl_r[PP_CT_SELIN]; // see [R12]
    assign port_data_lines_out = pd_out_r;
    assign port_data_lines_oe = epp_w ? !eng_read_w : !dir_in_w; // see [R9]
endmodule // pp_port

`default_nettype wire

/* File: dv/pp_port_chk.sv */
`timescale 1ns/100ps
`default_nettype none

module pp_port_chk
    import pp_pkg::*;
#(
    parameter int TMO_CYC = 8,
    parameter int IRQ_CYC = 5
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] port_mode,
    input wire logic [2:0] host_addr,
    input wire logic host_cs_n,
    input wire logic host_iow_n,
    input wire logic [7:0] host_d_in,
    input wire logic iochrdy_o,
    input wire logic iochrdy_oe,
    input wire logic irq_o,
    input wire logic irq_oe,
    input wire logic data_latch_pulse_n,
    input wire logic auto_line_feed_n,
    input wire logic peripheral_init_n,
    input wire logic select_peripheral_n,
    input wire logic port_data_lines_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic wr_ctrl;
    logic spp;
    logic [7:0] irq_len_r;
    assign wr_ctrl = !host_iow_n && !host_cs_n && host_addr == PP_OFS_CTRL;
    assign spp = port_mode == PP_MODE_SPP;
    // length of the current interrupt drive, read at its falling edge
    always_ff @(posedge mclk)
    begin
        irq_len_r <= irq_oe ? irq_len_r + 8'h1 : 8'h0;
    end
    sel_follow_a: assert property (
        $changed(select_peripheral_n) |-> $past(wr_ctrl, 2)
        && select_peripheral_n == !$past(host_d_in[3], 2))
        else $error("select-in moved without a control write");
    init_follow_a: assert property (
        $changed(peripheral_init_n) |-> $past(wr_ctrl, 2)
        && peripheral_init_n == $past(host_d_in[2], 2))
        else $error("init moved without a control write");
    afd_follow_a: assert property (
        spp && $changed(auto_line_feed_n) |-> $past(wr_ctrl, 2)
        && auto_line_feed_n == !$past(host_d_in[1], 2))
        else $error("autofeed moved without a control write");
    strobe_follow_a: assert property (
        spp && $changed(data_latch_pulse_n) |-> $past(wr_ctrl, 2)
        && data_latch_pulse_n == !$past(host_d_in[0], 2))
        else $error("strobe moved without a control write");
    ready_stall_a: assert property (
        iochrdy_oe |-> (port_mode == PP_MODE_EPP && !iochrdy_o)
        ##[1:60] !iochrdy_oe)
        else $error("ready stall outside EPP or too long");
    irq_width_a: assert property (
        $fell(irq_oe) && port_mode[1] |-> irq_len_r == IRQ_CYC)
        else $error("interrupt pulse has wrong length");
    irq_low_a: assert property (
        irq_oe && port_mode[1] |-> !irq_o)
        else $error("interrupt driven high in EPP or ECP");
    pd_drive_a: assert property (
        spp || (port_mode == PP_MODE_EPP && !data_latch_pulse_n)
        |-> port_data_lines_oe)
        else $error("data lines not driven");
endmodule // pp_port_chk

bind pp_port pp_port_chk #(.TMO_CYC(TMO_CYC), .IRQ_CYC(IRQ_CYC)) i_chk (.*);

`default_nettype wire

/* File: dv/pp_printer_model.sv */
`timescale 1ns/100ps
`default_nettype none

module pp_printer_model
#(
    parameter logic [7:0] RD_BYTE = 8'h96
)
(
    input wire logic mclk,
    input wire logic [1:0] hold,
    input wire logic data_latch_pulse_n,
    input wire logic auto_line_feed_n,
    input wire logic [7:0] pd,
    output logic busy,
    output logic peripheral_accept_n,
    output logic pd_en,
    output logic [7:0] pd_drv,
    output logic [7:0] got
);
    logic [2:0] ph_r = 3'h0;
    logic stb_d_r = 1'b1;
    logic afd_d_r = 1'b1;
    logic by_afd_r = 1'b0;
    logic trig;
    logic done;
    // a cycle starts on a falling strobe and ends when that strobe rises;
    // in EPP the write strobe stays low past the data strobe, so the
    // data strobe owns the cycle whenever it took part
    assign trig = (!data_latch_pulse_n && stb_d_r) ||
        (!auto_line_feed_n && afd_d_r);
    assign done = by_afd_r ? auto_line_feed_n : data_latch_pulse_n;
    always @(posedge mclk)
    begin
        stb_d_r <= data_latch_pulse_n;
        afd_d_r <= auto_line_feed_n;
        if (ph_r == 3'h2 && !data_latch_pulse_n)
            got <= pd;
        if (ph_r == 3'h0)
        begin
            ph_r <= {2'h0, trig};
            by_afd_r <= !auto_line_feed_n;
        end
        else if (ph_r != 3'h6 || done)
            ph_r <= ph_r == 3'h6 ? 3'h0 : ph_r + 3'h1;
    end
    assign busy = hold[0] || ph_r != 3'h0;
    assign peripheral_accept_n =
        !(hold[1] || ph_r == 3'h4 || ph_r == 3'h5);
    assign pd_en = !auto_line_feed_n && data_latch_pulse_n;
    assign pd_drv = RD_BYTE;
endmodule // pp_printer_model

`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb
    import pp_pkg::*;
;
    logic mclk, rst_n, host_cs_n, host_ior_n, host_iow_n, host_d_oe;
    logic [1:0] port_mode, hold;
    logic [2:0] host_addr;
    logic [7:0] host_d_in, host_d_out, port_data_lines_in, port_data_lines_out;
    logic [7:0] pd_drv, got, q;
    logic [7:0] pd_last = 8'h00;
    logic iochrdy_o, iochrdy_oe, irq_o, irq_oe, data_latch_pulse_n;
    logic auto_line_feed_n, peripheral_init_n, select_peripheral_n, busy;
    logic peripheral_accept_n, paper_out, peripheral_online;
    logic peripheral_fault_n, port_data_lines_oe, pd_en, stall;
    logic [3:0] pins;
    int error_cnt, checks_done, irq_cnt;

    pp_port #(.TMO_CYC(8)) i_dut (.*);
    pp_printer_model i_prn (.mclk, .hold, .data_latch_pulse_n,
        .auto_line_feed_n, .pd(port_data_lines_in), .busy,
        .peripheral_accept_n, .pd_en, .pd_drv, .got);

    // undriven lines flip every cycle so a stale byte cannot pass
    assign port_data_lines_in = port_data_lines_oe ? port_data_lines_out
        : pd_en ? pd_drv : ~pd_last;
    assign pins = {data_latch_pulse_n, auto_line_feed_n, peripheral_init_n,
        select_peripheral_n};
    always @(posedge mclk) pd_last <= port_data_lines_in;
    always @(posedge irq_oe) irq_cnt++;

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic give_verdict;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp,
        input logic [7:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // strobes stay low until the stall ends, then the answer is taken
    task automatic bus(input logic wr, input logic [2:0] a,
        input logic [7:0] d);
        int n;
        {host_addr, host_d_in, host_cs_n} = {a, d, 1'b0};
        {host_iow_n, host_ior_n} = {!wr, wr};
        stall = 1'b0;
        for (n = 0; n < 60 && (n < 5 || iochrdy_oe); n++)
        begin
            @(negedge mclk);
            stall |= iochrdy_oe;
        end
        if (n == 60)
        begin
            cmp("ready", 8'h00, 8'h01);
            give_verdict();
        end
        repeat (2) @(negedge mclk);
        if (!wr)
            cmp("read oe", 8'h01, {7'h0, host_d_oe});
        q = host_d_out;
        {host_cs_n, host_iow_n, host_ior_n} = 3'h7;
        repeat (4) @(negedge mclk);
    endtask

    task automatic t_status;
        logic [4:0] v [4] = '{5'h15, 5'h0a, 5'h1f, 5'h00};
        foreach (v[i])
        begin
            {hold, paper_out, peripheral_online, peripheral_fault_n} = v[i];
            repeat (3) @(negedge mclk);
            bus(1'b0, PP_OFS_STATUS, 8'h00);
            cmp("status", {~v[i][3], ~v[i][4], v[i][2:0], 3'h0},
                q);
        end
    endtask

    task automatic t_ctrl;
        logic [7:0] v [4] = '{8'h0f, 8'h00, 8'h05, 8'h0a};
        cmp("reset pins", 8'h0f, {4'h0, pins});
        foreach (v[i])
        begin
            bus(1'b1, PP_OFS_CTRL, v[i]);
            cmp("pins", {4'h0, ~v[i][0], ~v[i][1], v[i][2], ~v[i][3]},
                {4'h0, pins});
        end
        // leave every control line idle so the printer is not busy
        bus(1'b1, PP_OFS_CTRL, 8'h04);
    endtask

    task automatic t_spp;
        bus(1'b1, PP_OFS_CTRL, 8'h04);
        bus(1'b1, PP_OFS_DATA, 8'ha5);
        cmp("pd out", 8'ha5, port_data_lines_in);
        bus(1'b1, PP_OFS_CTRL, 8'h05);
        cmp("latched", 8'ha5, got);
        bus(1'b1, PP_OFS_CTRL, 8'h04);
    endtask

    // bidirectional mode: lines turned around, the printer's byte is read
    task automatic t_ps2;
        port_mode = PP_MODE_PS2;
        bus(1'b1, PP_OFS_CTRL, 8'h26);
        cmp("pd dir", 8'h00, {7'h0, port_data_lines_oe});
        bus(1'b0, PP_OFS_DATA, 8'h00);
        cmp("pd in", 8'h96, q);
        bus(1'b0, PP_OFS_CTRL, 8'h00);
        cmp("ctrl rd", 8'he6, q);
        bus(1'b1, PP_OFS_CTRL, 8'h04);
    endtask

    task automatic t_epp;
        int irq_base;
        port_mode = PP_MODE_EPP;
        bus(1'b1, PP_OFS_CTRL, 8'h14);
        irq_base = irq_cnt;
        bus(1'b1, PP_OFS_EPP_DATA, 8'h3c);
        repeat (20) @(negedge mclk);
        cmp("epp wr", 8'h3c, got);
        bus(1'b0, PP_OFS_EPP_DATA, 8'h00);
        cmp("epp rd", 8'h96, q);
        cmp("stall", 8'h01, {7'h0, stall});
        repeat (20) @(negedge mclk);
        cmp("irq pulses", 8'h02, 8'(irq_cnt - irq_base));
        // busy held high: the read ends at once and the trailer times out
        hold = 2'h1;
        bus(1'b0, PP_OFS_EPP_DATA, 8'h00);
        repeat (20) @(negedge mclk);
        bus(1'b0, PP_OFS_STATUS, 8'h00);
        cmp("tmo flag", 8'h01, {7'h0, q[0]});
        hold = 2'h0;
    endtask

    initial
    begin
        {rst_n, port_mode, host_addr, host_d_in, hold} = '0;
        {host_cs_n, host_ior_n, host_iow_n} = 3'h7;
        {paper_out, peripheral_online, peripheral_fault_n} = 3'h1;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        t_ctrl();
        t_status();
        t_spp();
        t_ps2();
        t_epp();
        give_verdict();
    end
endmodule // tb

`default_nettype wire
